// ---- rtl/thtt_pkg.sv ----
package thtt_pkg;

    // ------------------------------------------------------------
    // register window
    // ------------------------------------------------------------
    localparam logic [15:0] THTT_OFS_CTRL       = 16'h101c;
    localparam logic [15:0] THTT_OFS_FLAGS      = 16'h101e;
    localparam int          THTT_ADDR_W         = 16;
    localparam int          THTT_DATA_W         = 16;
    localparam int          THTT_TEMP_W         = 8;
    localparam int          THTT_NUM_TRIPS      = 6;

    // ------------------------------------------------------------
    // throttle control fields
    // ------------------------------------------------------------
    localparam int          THTT_CTRL_EN_BIT    = 7;
    localparam int          THTT_CTRL_ZONE_BIT  = 4;
    localparam int          THTT_CTRL_HALT_BIT  = 3;
    localparam int          THTT_CTRL_LOCK_BIT  = 0;
    localparam logic [7:0]  THTT_CTRL_RESET     = 8'h00;
    localparam logic [7:0]  THTT_CTRL_RW_MASK   = 8'h98;

    // ------------------------------------------------------------
    // trip event flag fields
    // ------------------------------------------------------------
    localparam int          THTT_FLAG_RISE_LSB  = 0;
    localparam int          THTT_FLAG_FALL_LSB  = 8;
    localparam logic [15:0] THTT_FLAGS_RESET    = 16'h0000;
    localparam logic [15:0] THTT_FLAGS_MASK     = 16'h3f3f;

    // ------------------------------------------------------------
    // trip point order, shared by rise and fall fields
    // ------------------------------------------------------------
    localparam int          THTT_TRIP_AUX0      = 0;
    localparam int          THTT_TRIP_AUX1      = 1;
    localparam int          THTT_TRIP_AUX2      = 2;
    localparam int          THTT_TRIP_AUX3      = 3;
    localparam int          THTT_TRIP_HOT       = 4;
    localparam int          THTT_TRIP_CAT       = 5;

endpackage

// ---- rtl/thtt_cross_detect.sv ----
`timescale 1ns/10ps
`default_nettype none

module thtt_cross_detect
    import thtt_pkg::*;
(
    input  wire logic                                     ref_clk,
    input  wire logic                                     rst_n,
    input  wire logic                                     sampleValid,
    input  wire logic [THTT_TEMP_W-1:0]                   tempSample,
    input  wire logic [THTT_NUM_TRIPS-1:0][THTT_TEMP_W-1:0] tripSetting,
    output var  logic [THTT_NUM_TRIPS-1:0]                aboveTrip,
    output logic      [THTT_NUM_TRIPS-1:0]                riseEvent,
    output logic      [THTT_NUM_TRIPS-1:0]                fallEvent
);

    // ------------------------------------------------------------
    // per trip point compare against the previous result
    // ------------------------------------------------------------
    logic [THTT_NUM_TRIPS-1:0] sampleAbove;
    logic [THTT_NUM_TRIPS-1:0] next_aboveTrip;

    genvar gi;
    generate
        for (gi = 0; gi < THTT_NUM_TRIPS; gi++) begin : g_trip
            assign sampleAbove[gi] = (tempSample >= tripSetting[gi]);
            assign riseEvent[gi]   = sampleValid & sampleAbove[gi] & ~aboveTrip[gi];
            assign fallEvent[gi]   = sampleValid & ~sampleAbove[gi] & aboveTrip[gi];

            property p_cross_rise;
                @(posedge ref_clk) disable iff (!rst_n)
                    riseEvent[gi] |=> aboveTrip[gi];
            endproperty
            a_cross_rise: assert property (p_cross_rise) else $error("rise left state low");
        end
    endgenerate

    always_comb begin
        next_aboveTrip = aboveTrip;
        if (sampleValid) begin
            next_aboveTrip = sampleAbove;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            aboveTrip <= '0;
        end else begin
            aboveTrip <= next_aboveTrip;
        end
    end

endmodule

`default_nettype wire

// ---- rtl/thtt_thermal_ctrl.sv ----
// Functional notes
// - control bit 7 is master enable; zero suppresses all hardware throttle actions
// - bit 4 zero throttles on hot, aux2, catastrophic; one on hot, catastrophic
// - bit 3 set: drive platform trip low when catastrophic point is reached
// - platform trip stays low once asserted until system reset
// - while lock bit is one, writes to control bits 7 to 1 are ignored
// - lock bit sets once by writing one; only reset clears it
// - flag bit 13 on falling crossing of catastrophic point
// - flag bit 12 on falling crossing of hot point
// - flag bits 11 to 8 on falling crossing of aux3 to aux0
// - flag bit 5 on rising crossing of catastrophic point
// - flag bit 4 on rising crossing of hot point
// - flag bits 3 to 1 on rising crossing of aux3 to aux1
// - flag bit 0 on rising crossing of aux0 point
// - flags stay set until software writes one; writing zero has no effect
// - set flags identify the cause of the thermal event output
`timescale 1ns/10ps
`default_nettype none

module thtt_thermal_ctrl
    import thtt_pkg::*;
(
    input  wire logic                      ref_clk,
    input  wire logic                      rst_n,
    input  wire logic [THTT_ADDR_W-1:0]    regAddr,
    input  wire logic                      regWrEn,
    input  wire logic                      regRdEn,
    input  wire logic [1:0]                regByteEn,
    input  wire logic [THTT_DATA_W-1:0]    regWrData,
    output var  logic [THTT_DATA_W-1:0]    regRdData,
    output var  logic                      regRdValid,
    input  wire logic                      sampleValid,
    input  wire logic [THTT_TEMP_W-1:0]    tempSample,
    input  wire logic [THTT_TEMP_W-1:0]    tripAux0,
    input  wire logic [THTT_TEMP_W-1:0]    tripAux1,
    input  wire logic [THTT_TEMP_W-1:0]    tripAux2,
    input  wire logic [THTT_TEMP_W-1:0]    tripAux3,
    input  wire logic [THTT_TEMP_W-1:0]    tripHot,
    input  wire logic [THTT_TEMP_W-1:0]    tripCat,
    output var  logic [THTT_NUM_TRIPS-1:0] liveSensorStatus,
    output var  logic                      throttleActive,
    output var  logic                      thermalEventPending,
    output var  logic                      platformThermalTripN
);

    // ------------------------------------------------------------
    // crossing detector
    // ------------------------------------------------------------
    logic [THTT_NUM_TRIPS-1:0][THTT_TEMP_W-1:0] tripSetting;
    logic [THTT_NUM_TRIPS-1:0]                  aboveTrip;
    logic [THTT_NUM_TRIPS-1:0]                  riseEvent;
    logic [THTT_NUM_TRIPS-1:0]                  fallEvent;

    assign tripSetting[THTT_TRIP_AUX0] = tripAux0;
    assign tripSetting[THTT_TRIP_AUX1] = tripAux1;
    assign tripSetting[THTT_TRIP_AUX2] = tripAux2;
    assign tripSetting[THTT_TRIP_AUX3] = tripAux3;
    assign tripSetting[THTT_TRIP_HOT]  = tripHot;
    assign tripSetting[THTT_TRIP_CAT]  = tripCat;

    thtt_cross_detect u_cross (
        .ref_clk     (ref_clk),
        .rst_n       (rst_n),
        .sampleValid (sampleValid),
        .tempSample  (tempSample),
        .tripSetting (tripSetting),
        .aboveTrip   (aboveTrip),
        .riseEvent   (riseEvent),
        .fallEvent   (fallEvent)
    );

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    logic       ctrlHit;
    logic       flagsHit;
    logic       ctrlWrite;
    logic [1:0] flagsLane;

    assign ctrlHit   = (regAddr == THTT_OFS_CTRL);
    assign flagsHit  = (regAddr == THTT_OFS_FLAGS);
    assign ctrlWrite = regWrEn & ctrlHit & regByteEn[0];
    assign flagsLane = (regWrEn & flagsHit) ? regByteEn : 2'h0;

    // ------------------------------------------------------------
    // throttle control register
    // ------------------------------------------------------------
    logic [7:0] throttleControl;
    logic [7:0] next_throttleControl;
    logic       ctrlLocked;

    assign ctrlLocked = throttleControl[THTT_CTRL_LOCK_BIT];

    always_comb begin
        next_throttleControl = throttleControl;
        if (ctrlWrite) begin
            if (!ctrlLocked) begin
                next_throttleControl = regWrData[7:0] & THTT_CTRL_RW_MASK;
            end
            if (regWrData[THTT_CTRL_LOCK_BIT] || ctrlLocked) begin
                next_throttleControl[THTT_CTRL_LOCK_BIT] = 1'b1;
            end else begin
                next_throttleControl[THTT_CTRL_LOCK_BIT] = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            throttleControl <= THTT_CTRL_RESET;
        end else begin
            throttleControl <= next_throttleControl;
        end
    end

    // ------------------------------------------------------------
    // trip event flags, set wins over clear
    // ------------------------------------------------------------
    logic [15:0] tripEventFlags;
    logic [15:0] next_tripEventFlags;
    logic [15:0] flagSet;
    logic [15:0] flagClear;
    logic        next_thermalEventPending;

    always_comb begin
        flagSet = '0;
        flagSet[THTT_FLAG_RISE_LSB +: THTT_NUM_TRIPS] = riseEvent;
        flagSet[THTT_FLAG_FALL_LSB +: THTT_NUM_TRIPS] = fallEvent;
        flagClear = {regWrData[15:8] & {8{flagsLane[1]}}, regWrData[7:0] & {8{flagsLane[0]}}};
        next_tripEventFlags = ((tripEventFlags & ~flagClear) | flagSet) & THTT_FLAGS_MASK;
        next_thermalEventPending = |next_tripEventFlags;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tripEventFlags      <= THTT_FLAGS_RESET;
            thermalEventPending <= 1'b0;
        end else begin
            tripEventFlags      <= next_tripEventFlags;
            thermalEventPending <= next_thermalEventPending;
        end
    end

    // ------------------------------------------------------------
    // hardware actions
    // ------------------------------------------------------------
    logic masterEnable;
    logic zoneHotCatOnly;
    logic haltOnCat;
    logic next_throttleActive;
    logic next_platformThermalTripN;

    assign masterEnable   = throttleControl[THTT_CTRL_EN_BIT];
    assign zoneHotCatOnly = throttleControl[THTT_CTRL_ZONE_BIT];
    assign haltOnCat      = throttleControl[THTT_CTRL_HALT_BIT];

    always_comb begin
        next_throttleActive = masterEnable & (aboveTrip[THTT_TRIP_HOT] |
            aboveTrip[THTT_TRIP_CAT] | (~zoneHotCatOnly & aboveTrip[THTT_TRIP_AUX2]));
        next_platformThermalTripN = platformThermalTripN;
        if (masterEnable && haltOnCat && aboveTrip[THTT_TRIP_CAT]) begin
            next_platformThermalTripN = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            throttleActive       <= 1'b0;
            platformThermalTripN <= 1'b1;
            liveSensorStatus     <= '0;
        end else begin
            throttleActive       <= next_throttleActive;
            platformThermalTripN <= next_platformThermalTripN;
            liveSensorStatus     <= aboveTrip;
        end
    end

    // ------------------------------------------------------------
    // read path, one cycle after the strobe
    // ------------------------------------------------------------
    logic [THTT_DATA_W-1:0] next_regRdData;

    always_comb begin
        next_regRdData = regRdData;
        if (regRdEn) begin
            if (ctrlHit) begin
                next_regRdData = {8'h00, throttleControl};
            end else if (flagsHit) begin
                next_regRdData = tripEventFlags;
            end else begin
                next_regRdData = 16'h0000;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            regRdData  <= 16'h0000;
            regRdValid <= 1'b0;
        end else begin
            regRdData  <= next_regRdData;
            regRdValid <= regRdEn;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_aux2_only;
        aboveTrip[THTT_TRIP_AUX2] && !aboveTrip[THTT_TRIP_HOT] && !aboveTrip[THTT_TRIP_CAT];
    endsequence

    sequence s_cat_halt;
        masterEnable && haltOnCat && aboveTrip[THTT_TRIP_CAT];
    endsequence

    property p_master_off;
        @(posedge ref_clk) disable iff (!rst_n)
            !masterEnable |=> !throttleActive;
    endproperty
    a_master_off: assert property (p_master_off) else $error("throttle while disabled");

    property p_zone_select;
        @(posedge ref_clk) disable iff (!rst_n)
            (masterEnable ##0 s_aux2_only) |=> (throttleActive == !$past(zoneHotCatOnly));
    endproperty
    a_zone_select: assert property (p_zone_select) else $error("aux2 zone select wrong");

    property p_cat_halt;
        @(posedge ref_clk) disable iff (!rst_n)
            s_cat_halt |=> !platformThermalTripN;
    endproperty
    a_cat_halt: assert property (p_cat_halt) else $error("trip output not asserted");

    property p_trip_sticky;
        @(posedge ref_clk) disable iff (!rst_n)
            !platformThermalTripN |=> !platformThermalTripN [*8];
    endproperty
    a_trip_sticky: assert property (p_trip_sticky) else $error("trip output released");

    property p_lock_blocks;
        @(posedge ref_clk) disable iff (!rst_n)
            (ctrlLocked && ctrlWrite) |=> $stable(throttleControl);
    endproperty
    a_lock_blocks: assert property (p_lock_blocks) else $error("locked control changed");

    property p_lock_once;
        @(posedge ref_clk) disable iff (!rst_n)
            (ctrlWrite && regWrData[THTT_CTRL_LOCK_BIT]) |=> ctrlLocked [*4];
    endproperty
    a_lock_once: assert property (p_lock_once) else $error("lock bit not held");

    property p_fall_cat;
        @(posedge ref_clk) disable iff (!rst_n)
            (sampleValid && tempSample < tripCat && aboveTrip[THTT_TRIP_CAT]) |=>
                tripEventFlags[13];
    endproperty
    a_fall_cat: assert property (p_fall_cat) else $error("cat fall flag missing");

    property p_fall_hot;
        @(posedge ref_clk) disable iff (!rst_n)
            (sampleValid && tempSample < tripHot && aboveTrip[THTT_TRIP_HOT]) |=>
                tripEventFlags[12];
    endproperty
    a_fall_hot: assert property (p_fall_hot) else $error("hot fall flag missing");

    property p_fall_aux3;
        @(posedge ref_clk) disable iff (!rst_n)
            (sampleValid && tempSample < tripAux3 && aboveTrip[THTT_TRIP_AUX3]) |=>
                tripEventFlags[11];
    endproperty
    a_fall_aux3: assert property (p_fall_aux3) else $error("aux3 fall flag missing");

    property p_rise_cat;
        @(posedge ref_clk) disable iff (!rst_n)
            (sampleValid && tempSample >= tripCat && !aboveTrip[THTT_TRIP_CAT]) |=>
                tripEventFlags[5];
    endproperty
    a_rise_cat: assert property (p_rise_cat) else $error("cat rise flag missing");

    property p_rise_hot;
        @(posedge ref_clk) disable iff (!rst_n)
            (sampleValid && tempSample >= tripHot && !aboveTrip[THTT_TRIP_HOT]) |=>
                tripEventFlags[4];
    endproperty
    a_rise_hot: assert property (p_rise_hot) else $error("hot rise flag missing");

    property p_rise_aux1;
        @(posedge ref_clk) disable iff (!rst_n)
            (sampleValid && tempSample >= tripAux1 && !aboveTrip[THTT_TRIP_AUX1]) |=>
                tripEventFlags[1];
    endproperty
    a_rise_aux1: assert property (p_rise_aux1) else $error("aux1 rise flag missing");

    property p_rise_aux0;
        @(posedge ref_clk) disable iff (!rst_n)
            (sampleValid && tempSample >= tripAux0 && !aboveTrip[THTT_TRIP_AUX0]) |=>
                tripEventFlags[0];
    endproperty
    a_rise_aux0: assert property (p_rise_aux0) else $error("aux0 rise flag missing");

    property p_w1c_clear;
        @(posedge ref_clk) disable iff (!rst_n)
            (flagsLane[0] && regWrData[0] && !riseEvent[0]) |=> !tripEventFlags[0];
    endproperty
    a_w1c_clear: assert property (p_w1c_clear) else $error("flag not cleared by one");

    property p_flag_hold;
        @(posedge ref_clk) disable iff (!rst_n)
            (tripEventFlags[4] && !(flagsLane[0] && regWrData[4])) |=> tripEventFlags[4];
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without clear");

    property p_event_cause;
        @(posedge ref_clk) disable iff (!rst_n)
            thermalEventPending == (tripEventFlags != 16'h0000);
    endproperty
    a_event_cause: assert property (p_event_cause) else $error("event without cause");

    property p_reserved_zero;
        @(posedge ref_clk) disable iff (!rst_n)
            ((tripEventFlags & ~THTT_FLAGS_MASK) == 16'h0000) &&
            ((throttleControl & ~(THTT_CTRL_RW_MASK | 8'h01)) == 8'h00);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

endmodule

`default_nettype wire

// ---- verification/thermal_throttle_trip_status_test.sv ----
`timescale 1ns/10ps
`default_nettype none

module thermal_throttle_trip_status_test
    import thtt_pkg::*;
;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  temp;
        logic [15:0] flags;
        logic [5:0]  live;
    } thtt_row_t;

    localparam int TIMEOUT = 5000;

    logic                      ref_clk      = 1'b0;
    logic                      rst_n        = 1'b0;
    logic [THTT_ADDR_W-1:0]    regAddr      = '0;
    logic                      regWrEn      = 1'b0;
    logic                      regRdEn      = 1'b0;
    logic [1:0]                regByteEn    = 2'b00;
    logic [THTT_DATA_W-1:0]    regWrData    = '0;
    logic                      sampleValid  = 1'b0;
    logic [THTT_TEMP_W-1:0]    tempSample   = '0;
    logic [THTT_TEMP_W-1:0]    tripCat      = 8'h3c;
    logic [THTT_DATA_W-1:0]    regRdData;
    logic                      regRdValid;
    logic [THTT_NUM_TRIPS-1:0] liveSensorStatus;
    logic                      throttleActive;
    logic                      thermalEventPending;
    logic                      platformThermalTripN;
    int                        failures     = 0;
    int                        testsRun     = 0;
    int                        cycleCount   = 0;
    thtt_row_t                 rows [9]     = '{
        '{8'h00, 16'h0000, 6'h00}, '{8'h23, 16'h0007, 6'h07}, '{8'h2d, 16'h0008, 6'h0f},
        '{8'h37, 16'h0010, 6'h1f}, '{8'h3c, 16'h0020, 6'h3f}, '{8'h05, 16'h3f00, 6'h00},
        '{8'h1e, 16'h0007, 6'h07}, '{8'h41, 16'h0038, 6'h3f}, '{8'h00, 16'h3f00, 6'h00}};

    thtt_thermal_ctrl u_thtt_thermal_ctrl (
        .ref_clk              (ref_clk),
        .rst_n                (rst_n),
        .regAddr              (regAddr),
        .regWrEn              (regWrEn),
        .regRdEn              (regRdEn),
        .regByteEn            (regByteEn),
        .regWrData            (regWrData),
        .regRdData            (regRdData),
        .regRdValid           (regRdValid),
        .sampleValid          (sampleValid),
        .tempSample           (tempSample),
        .tripAux0             (8'h0a),
        .tripAux1             (8'h14),
        .tripAux2             (8'h1e),
        .tripAux3             (8'h28),
        .tripHot              (8'h32),
        .tripCat              (tripCat),
        .liveSensorStatus     (liveSensorStatus),
        .throttleActive       (throttleActive),
        .thermalEventPending  (thermalEventPending),
        .platformThermalTripN (platformThermalTripN)
    );

    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------
    // report and compare tasks
    // ------------------------------------------------------------
    task automatic final_report;
        $display("counts: %0d compared, %0d mismatched", testsRun, failures);
        if (failures == 0 && testsRun > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        testsRun++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        testsRun++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %b, seen %b", what, exp, got);
        end
    endtask

    always @(posedge ref_clk) begin
        cycleCount++;
        if (cycleCount == TIMEOUT) begin
            failures++;
            final_report();
        end
    end

    // ------------------------------------------------------------
    // bus and sensor drivers
    // ------------------------------------------------------------
    task automatic settle;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [1:0] be);
        @(posedge ref_clk);
        regAddr   <= a;
        regWrData <= d;
        regByteEn <= be;
        regWrEn   <= 1'b1;
        @(posedge ref_clk);
        regWrEn   <= 1'b0;
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge ref_clk);
        regRdEn <= 1'b0;
        #1;
        chk_bit("regRdValid", 1'b1, regRdValid);
        chk_val("regRdData", exp, regRdData);
    endtask

    task automatic sample(input logic [7:0] t);
        @(posedge ref_clk);
        tempSample  <= t;
        sampleValid <= 1'b1;
        @(posedge ref_clk);
        sampleValid <= 1'b0;
        settle();
    endtask

    task automatic do_reset;
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        do_reset();
        rd_chk(THTT_OFS_CTRL, 16'h0000);
        rd_chk(THTT_OFS_FLAGS, 16'h0000);
        chk_bit("platformThermalTripN", 1'b1, platformThermalTripN);
        $display("test reset_values done");

        foreach (rows[i]) begin
            sample(rows[i].temp);
            rd_chk(THTT_OFS_FLAGS, rows[i].flags);
            chk_val("liveSensorStatus", {10'h000, rows[i].live}, {10'h000, liveSensorStatus});
            chk_bit("thermalEventPending", rows[i].flags != 0, thermalEventPending);
            chk_bit("throttleActive", 1'b0, throttleActive);
            wr(THTT_OFS_FLAGS, 16'hffff, 2'b11);
            rd_chk(THTT_OFS_FLAGS, 16'h0000);
        end
        $display("test crossing_table done");

        sample(8'h41);
        wr(THTT_OFS_FLAGS, 16'h0000, 2'b11);
        rd_chk(THTT_OFS_FLAGS, 16'h003f);
        wr(THTT_OFS_FLAGS, 16'h0008, 2'b01);
        rd_chk(THTT_OFS_FLAGS, 16'h0037);
        wr(THTT_OFS_FLAGS, 16'hffff, 2'b10);
        rd_chk(THTT_OFS_FLAGS, 16'h0037);
        wr(THTT_OFS_FLAGS, 16'hc0c0, 2'b11);
        rd_chk(THTT_OFS_FLAGS, 16'h0037);
        sample(8'h00);
        rd_chk(THTT_OFS_FLAGS, 16'h3f37);
        wr(THTT_OFS_FLAGS, 16'hffff, 2'b10);
        rd_chk(THTT_OFS_FLAGS, 16'h0037);
        wr(THTT_OFS_FLAGS, 16'hffff, 2'b11);
        settle();
        chk_bit("thermalEventPending", 1'b0, thermalEventPending);
        rd_chk(16'h101d, 16'h0000);
        wr(16'h1020, 16'h00ff, 2'b11);
        rd_chk(THTT_OFS_CTRL, 16'h0000);
        $display("test flag_clearing done");

        wr(THTT_OFS_CTRL, 16'h0090, 2'b01);
        sample(8'h23);
        chk_bit("throttleActive", 1'b0, throttleActive);
        wr(THTT_OFS_CTRL, 16'h0080, 2'b01);
        settle();
        chk_bit("throttleActive", 1'b1, throttleActive);
        wr(THTT_OFS_CTRL, 16'h0000, 2'b01);
        settle();
        chk_bit("throttleActive", 1'b0, throttleActive);
        wr(THTT_OFS_CTRL, 16'h009e, 2'b01);
        rd_chk(THTT_OFS_CTRL, 16'h0098);
        sample(8'h37);
        chk_bit("throttleActive", 1'b1, throttleActive);
        $display("test zone_select done");

        wr(THTT_OFS_CTRL, 16'h0008, 2'b01);
        sample(8'h41);
        chk_bit("platformThermalTripN", 1'b1, platformThermalTripN);
        sample(8'h00);
        wr(THTT_OFS_CTRL, 16'h0088, 2'b01);
        sample(8'h41);
        chk_bit("platformThermalTripN", 1'b0, platformThermalTripN);
        sample(8'h00);
        wr(THTT_OFS_CTRL, 16'h0000, 2'b01);
        settle();
        chk_bit("platformThermalTripN", 1'b0, platformThermalTripN);
        do_reset();
        chk_bit("platformThermalTripN", 1'b1, platformThermalTripN);
        $display("test halt_sticky done");

        wr(THTT_OFS_CTRL, 16'h0080, 2'b10);
        rd_chk(THTT_OFS_CTRL, 16'h0000);
        wr(THTT_OFS_CTRL, 16'h0001, 2'b01);
        rd_chk(THTT_OFS_CTRL, 16'h0001);
        wr(THTT_OFS_CTRL, 16'h0098, 2'b01);
        rd_chk(THTT_OFS_CTRL, 16'h0001);
        wr(THTT_OFS_CTRL, 16'h0000, 2'b01);
        rd_chk(THTT_OFS_CTRL, 16'h0001);
        do_reset();
        rd_chk(THTT_OFS_CTRL, 16'h0000);
        wr(THTT_OFS_CTRL, 16'h0099, 2'b01);
        wr(THTT_OFS_CTRL, 16'h0000, 2'b01);
        rd_chk(THTT_OFS_CTRL, 16'h0099);
        $display("test lock done");

        @(posedge ref_clk);
        tripCat <= 8'h46;
        sample(8'h41);
        rd_chk(THTT_OFS_FLAGS, 16'h001f);
        chk_val("liveSensorStatus", 16'h001f, {10'h000, liveSensorStatus});
        chk_bit("platformThermalTripN", 1'b1, platformThermalTripN);
        chk_bit("throttleActive", 1'b1, throttleActive);
        $display("test trip_setting done");

        final_report();
    end

endmodule

`default_nettype wire
